/* File: hw/tsn_defs.svh */
`ifndef TSN_DEFS_SVH
`define TSN_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TSN_OFF_CTRL       8'h00
`define TSN_OFF_STATUS     8'h04
`define TSN_OFF_MASK       8'h08
`define TSN_OFF_NOTIFY     8'h0C
`define TSN_OFF_PEND       8'h10
`define TSN_OFF_LAMP       8'h14
`define TSN_OFF_CFG_BASE   8'h40

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define TSN_CTRL_WORD_LINK 0
`define TSN_CTRL_VER5      1
`define TSN_CTRL_SHOW      2
`define TSN_CTRL_LEAVE     3
`define TSN_CTRL_RST       2'h0

// ----------------------------------------------------------------------------
// Status and mask fields
// ----------------------------------------------------------------------------
`define TSN_ST_WRITE       0
`define TSN_ST_SNAP        1
`define TSN_ST_PRESS       2
`define TSN_ST_W           3
`define TSN_ST_RST         3'h0
`define TSN_MASK_RST       3'h0

// ----------------------------------------------------------------------------
// Per-switch configuration fields
// ----------------------------------------------------------------------------
`define TSN_CFG_ADDR_LSB   0
`define TSN_CFG_ADDR_MSB   15
`define TSN_CFG_IDX_LSB    16
`define TSN_CFG_IDX_MSB    19
`define TSN_CFG_OP_LSB     20
`define TSN_CFG_OP_MSB     21
`define TSN_CFG_FLASH      22
`define TSN_CFG_AREA_LSB   23
`define TSN_CFG_AREA_MSB   25
`define TSN_CFG_RST        26'h0000000

// ----------------------------------------------------------------------------
// Controller memory
// ----------------------------------------------------------------------------
`define TSN_WORD_W         16
`define TSN_RELAY_LAST     16'h00C7
`define TSN_RELAY_TO_CORE  16'h03E8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSN_CLK_PERIOD_NS  25
`define TSN_BLINK_HALF_MS  500

`endif

/* File: hw/tsn_job_if.sv */
`timescale 1ns/1ps
interface tsn_job_if;
    logic                  valid;
    logic                  ready;
    logic                  is_read;
    tsn_pkg::tsn_area_type area;
    logic [15:0]           addr;
    logic [15:0]           data;
    logic [15:0]           mask;
    logic                  done;
    logic [15:0]           rdata;

    modport issuer (output valid, is_read, area, addr, data, mask,
                    input  ready, done, rdata);
    modport engine (input  valid, is_read, area, addr, data, mask,
                    output ready, done, rdata);
endinterface

/* File: hw/tsn_mem_engine.sv */
`timescale 1ns/1ps
`include "tsn_defs.svh"
module tsn_mem_engine (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // Job side
    tsn_job_if.engine         job,
    // Controller memory port
    output logic              mem_req,
    output logic              mem_wr,
    output tsn_pkg::tsn_area_type mem_area,
    output logic [15:0]       mem_addr,
    output logic [15:0]       mem_wdata,
    output logic [15:0]       mem_mask,
    input  wire logic         mem_ack,
    input  wire logic [15:0]  mem_rdata
);
    tsn_pkg::tsn_eng_state_type state;
    logic                       done_q;
    logic [15:0]                rdata_q;
    wire                        take = job.valid && (state == tsn_pkg::TSN_ENG_IDLE);
    wire                        relay_low = (job.area == tsn_pkg::TSN_AREA_LINK_RELAY) &&
                                            (job.addr <= `TSN_RELAY_LAST);
    // Low link relay words live in the core I/O area of the controller
    wire tsn_pkg::tsn_area_type xl_area = relay_low ? tsn_pkg::TSN_AREA_CORE_IO : job.area;
    wire [15:0]                 xl_addr = relay_low ? 16'(job.addr + `TSN_RELAY_TO_CORE)
                                                    : job.addr;

    assign job.ready = (state == tsn_pkg::TSN_ENG_IDLE);
    assign job.done  = done_q;
    assign job.rdata = rdata_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= tsn_pkg::TSN_ENG_IDLE;
            mem_req   <= 1'b0;
            mem_wr    <= 1'b0;
            mem_area  <= tsn_pkg::TSN_AREA_CORE_IO;
            mem_addr  <= 16'h0000;
            mem_wdata <= 16'h0000;
            mem_mask  <= 16'h0000;
            done_q    <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            case (state)
                tsn_pkg::TSN_ENG_IDLE: begin
                    if (take) begin
                        // Data and mask go out in one transfer so the word never tears
                        state     <= tsn_pkg::TSN_ENG_REQ;
                        mem_req   <= 1'b1;
                        mem_wr    <= !job.is_read;
                        mem_area  <= xl_area;
                        mem_addr  <= xl_addr;
                        mem_wdata <= job.data;
                        mem_mask  <= job.mask;
                    end
                end
                tsn_pkg::TSN_ENG_REQ: begin
                    if (mem_ack) begin
                        state   <= tsn_pkg::TSN_ENG_IDLE;
                        mem_req <= 1'b0;
                        done_q  <= 1'b1;
                        rdata_q <= mem_rdata;
                    end
                end
                default: begin
                    state   <= tsn_pkg::TSN_ENG_IDLE;
                    mem_req <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: hw/tsn_pkg.sv */
package tsn_pkg;

    typedef enum logic [1:0] {
        TSN_OP_MOMENTARY = 2'h0,
        TSN_OP_ALTERNATE = 2'h1,
        TSN_OP_SET       = 2'h2,
        TSN_OP_RESET     = 2'h3
    } tsn_op_type;

    typedef enum logic [2:0] {
        TSN_AREA_CORE_IO          = 3'h0,
        TSN_AREA_HOLDING          = 3'h1,
        TSN_AREA_AUXILIARY        = 3'h2,
        TSN_AREA_LINK_RELAY       = 3'h3,
        TSN_AREA_DATA_MEMORY      = 3'h4,
        TSN_AREA_EXTENDED_MEMORY  = 3'h5,
        TSN_AREA_INTERNAL_RELAY   = 3'h6
    } tsn_area_type;

    typedef enum logic [1:0] {
        TSN_ENG_IDLE = 2'b01,
        TSN_ENG_REQ  = 2'b10
    } tsn_eng_state_type;

endpackage

/* File: hw/tsn_top.sv */
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "tsn_defs.svh"
module tsn_top #(
    parameter int NUM_SW       = 8,
    parameter int BLINK_CYCLES = `TSN_BLINK_HALF_MS * 1000000 / `TSN_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    output logic                   irq,
    // Touch panel and screen
    input  wire logic [NUM_SW-1:0] sw_pressed,
    input  wire logic [NUM_SW-1:0] lamp_bit,
    input  wire logic              screen_show,
    input  wire logic              screen_leave,
    output logic [NUM_SW-1:0]      sw_lit,
    // Controller memory port
    output logic                   mem_req,
    output logic                   mem_wr,
    output tsn_pkg::tsn_area_type  mem_area,
    output logic [15:0]            mem_addr,
    output logic [15:0]            mem_wdata,
    output logic [15:0]            mem_mask,
    input  wire logic              mem_ack,
    input  wire logic [15:0]       mem_rdata
);
    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    // Configuration words occupy 0x40..0x5C, so eight switches at most
    if (NUM_SW < 1 || NUM_SW > 8) begin : g_bad_num_sw
        $error("NUM_SW must be 1 to 8");
    end
    if (BLINK_CYCLES < 2) begin : g_bad_blink
        $error("BLINK_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    function automatic logic [15:0] bit_of(input logic [3:0] idx);
        bit_of = 16'h0001 << idx;
    endfunction

    function automatic logic [2:0] first_set(input logic [NUM_SW-1:0] vec);
        first_set = 3'h0;
        for (int k = NUM_SW - 1; k >= 0; k--) begin
            if (vec[k]) begin
                first_set = k[2:0];
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [1:0]                ctrl;
    logic [`TSN_ST_W-1:0]      status;
    logic [`TSN_ST_W-1:0]      mask;
    logic [25:0]               cfg [NUM_SW];
    logic                      shown;
    logic [NUM_SW-1:0]         press_q;
    logic [NUM_SW-1:0]         nbit;
    logic [NUM_SW-1:0]         rd_pend;
    logic [NUM_SW-1:0]         wr_pend;
    logic [15:0]               snap [NUM_SW];
    logic                      busy;
    logic [2:0]                owner;
    logic                      owner_read;
    logic [24:0]               blink_cnt;
    logic                      blink_phase;

    wire                       word_link = ctrl[`TSN_CTRL_WORD_LINK];
    wire                       ver5      = ctrl[`TSN_CTRL_VER5];
    wire                       ctrl_hit  = reg_wr && (reg_addr == `TSN_OFF_CTRL);
    wire                       show_evt  = screen_show ||
                                           (ctrl_hit && reg_wdata[`TSN_CTRL_SHOW]);
    wire                       leave_evt = screen_leave ||
                                           (ctrl_hit && reg_wdata[`TSN_CTRL_LEAVE]);
    wire                       cfg_sel   = (reg_addr[7:5] == 3'(`TSN_OFF_CFG_BASE >> 5)) &&
                                           (reg_addr[1:0] == 2'h0);
    wire [2:0]                 cfg_idx   = reg_addr[4:2];

    tsn_job_if job ();

    // ------------------------------------------------------------------------
    // Per-switch notify logic
    // ------------------------------------------------------------------------
    logic [NUM_SW-1:0]         elig;
    logic [NUM_SW-1:0]         press_evt;
    logic [15:0]               sw_data [NUM_SW];
    logic [15:0]               sw_mask [NUM_SW];
    wire                       issue = job.valid && job.ready;
    wire                       rd_done = job.done && owner_read;
    wire [2:0]                 owner_next = first_set(elig);

    for (genvar i = 0; i < NUM_SW; i++) begin : g_sw
        wire [3:0]  idx   = cfg[i][`TSN_CFG_IDX_MSB:`TSN_CFG_IDX_LSB];
        wire        flash = cfg[i][`TSN_CFG_FLASH];
        wire tsn_pkg::tsn_area_type area =
            tsn_pkg::tsn_area_type'(cfg[i][`TSN_CFG_AREA_MSB:`TSN_CFG_AREA_LSB]);
        // Only the newer link version offers the other operation kinds
        wire tsn_pkg::tsn_op_type op = ver5 ?
            tsn_pkg::tsn_op_type'(cfg[i][`TSN_CFG_OP_MSB:`TSN_CFG_OP_LSB]) :
            tsn_pkg::TSN_OP_MOMENTARY;
        wire        mom   = (op == tsn_pkg::TSN_OP_MOMENTARY);
        wire        word  = word_link && (area == tsn_pkg::TSN_AREA_DATA_MEMORY);
        wire        rise  = shown && sw_pressed[i] && !press_q[i];
        wire        fall  = shown && !sw_pressed[i] && press_q[i];
        wire        drop  = leave_evt && mom && nbit[i];
        wire        grant = issue && (owner_next == 3'(i));
        wire        mine_rd = rd_done && (owner == 3'(i));
        logic       next_nbit;

        always_comb begin
            next_nbit = nbit[i];
            if (mine_rd) begin
                next_nbit = job.rdata[idx];
            end
            case (op)
                tsn_pkg::TSN_OP_MOMENTARY: begin
                    if (drop) begin
                        next_nbit = 1'b0;
                    end else if (rise) begin
                        next_nbit = 1'b1;
                    end else if (fall) begin
                        next_nbit = 1'b0;
                    end
                end
                tsn_pkg::TSN_OP_ALTERNATE: begin
                    if (rise) begin
                        next_nbit = !next_nbit;
                    end
                end
                tsn_pkg::TSN_OP_SET: begin
                    if (rise) begin
                        next_nbit = 1'b1;
                    end
                end
                tsn_pkg::TSN_OP_RESET: begin
                    if (rise) begin
                        next_nbit = 1'b0;
                    end
                end
                default: begin
                    next_nbit = nbit[i];
                end
            endcase
        end

        assign press_evt[i] = rise;
        // A switch waiting for its snapshot must not write a stale word
        assign elig[i]      = rd_pend[i] || wr_pend[i];
        assign sw_data[i]   = (word && mom) ? (nbit[i] ? bit_of(idx) : 16'h0000)
                            : word ? ((snap[i] & ~bit_of(idx)) |
                                      (nbit[i] ? bit_of(idx) : 16'h0000))
                            : (nbit[i] ? bit_of(idx) : 16'h0000);
        assign sw_mask[i]   = word ? 16'hFFFF : bit_of(idx);

        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                press_q[i] <= 1'b0;
                nbit[i]    <= 1'b0;
                rd_pend[i] <= 1'b0;
                wr_pend[i] <= 1'b0;
                snap[i]    <= 16'h0000;
                sw_lit[i]  <= 1'b0;
            end else begin
                press_q[i] <= sw_pressed[i];
                nbit[i]    <= next_nbit;
                // Any change of the bit is pushed out unasked; new events win
                if (rise || fall || drop) begin
                    wr_pend[i] <= 1'b1;
                end else if (grant && !rd_pend[i]) begin
                    wr_pend[i] <= 1'b0;
                end
                if (show_evt && !mom) begin
                    rd_pend[i] <= 1'b1;
                end else if (grant) begin
                    rd_pend[i] <= 1'b0;
                end
                if (mine_rd) begin
                    snap[i] <= job.rdata;
                end else if (grant && !rd_pend[i] && word) begin
                    snap[i] <= sw_data[i];
                end
                sw_lit[i] <= lamp_bit[i] && (!flash || blink_phase);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Job selection
    // ------------------------------------------------------------------------
    assign job.valid   = !busy && (elig != '0);
    assign job.is_read = rd_pend[owner_next];
    assign job.area    = tsn_pkg::tsn_area_type'(
                         cfg[owner_next][`TSN_CFG_AREA_MSB:`TSN_CFG_AREA_LSB]);
    assign job.addr    = cfg[owner_next][`TSN_CFG_ADDR_MSB:`TSN_CFG_ADDR_LSB];
    assign job.data    = sw_data[owner_next];
    assign job.mask    = rd_pend[owner_next] ? 16'h0000 : sw_mask[owner_next];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy       <= 1'b0;
            owner      <= 3'h0;
            owner_read <= 1'b0;
            shown      <= 1'b0;
        end else begin
            if (issue) begin
                busy       <= 1'b1;
                owner      <= owner_next;
                owner_read <= job.is_read;
            end else if (job.done) begin
                busy <= 1'b0;
            end
            if (show_evt) begin
                shown <= 1'b1;
            end else if (leave_evt) begin
                shown <= 1'b0;
            end
        end
    end

    tsn_mem_engine u_engine (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .job       (job.engine),
        .mem_req   (mem_req),
        .mem_wr    (mem_wr),
        .mem_area  (mem_area),
        .mem_addr  (mem_addr),
        .mem_wdata (mem_wdata),
        .mem_mask  (mem_mask),
        .mem_ack   (mem_ack),
        .mem_rdata (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Flash timing
    // ------------------------------------------------------------------------
    // One half period per phase; a slow divider costs only a counter
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt   <= 25'h0000000;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 25'(BLINK_CYCLES - 1)) begin
            blink_cnt   <= 25'h0000000;
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 25'h0000001;
        end
    end

    // ------------------------------------------------------------------------
    // Register access and interrupt
    // ------------------------------------------------------------------------
    wire [`TSN_ST_W-1:0] st_set = {(press_evt != '0),
                                   rd_done,
                                   job.done && !owner_read};
    wire [`TSN_ST_W-1:0] st_clr = (reg_wr && reg_addr == `TSN_OFF_STATUS) ?
                                  reg_wdata[`TSN_ST_W-1:0] : '0;
    wire [31:0]          rd_mux = (reg_addr == `TSN_OFF_CTRL)   ? {30'h0, ctrl}
                                : (reg_addr == `TSN_OFF_STATUS) ? {29'h0, status}
                                : (reg_addr == `TSN_OFF_MASK)   ? {29'h0, mask}
                                : (reg_addr == `TSN_OFF_NOTIFY) ? 32'(nbit)
                                : (reg_addr == `TSN_OFF_PEND)   ? 32'({rd_pend, wr_pend})
                                : (reg_addr == `TSN_OFF_LAMP)   ? 32'(lamp_bit)
                                : (cfg_sel && cfg_idx < NUM_SW) ? {6'h00, cfg[cfg_idx]}
                                : 32'h00000000;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl      <= `TSN_CTRL_RST;
            status    <= `TSN_ST_RST;
            mask      <= `TSN_MASK_RST;
            reg_rdata <= 32'h00000000;
            irq       <= 1'b0;
            for (int k = 0; k < NUM_SW; k++) begin
                cfg[k] <= `TSN_CFG_RST;
            end
        end else begin
            if (ctrl_hit) begin
                ctrl <= reg_wdata[1:0];
            end
            if (reg_wr && reg_addr == `TSN_OFF_MASK) begin
                mask <= reg_wdata[`TSN_ST_W-1:0];
            end
            if (reg_wr && cfg_sel && cfg_idx < NUM_SW) begin
                cfg[cfg_idx] <= reg_wdata[25:0];
            end
            // Set beats clear in the same cycle
            status    <= (status & ~st_clr) | st_set;
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
            irq       <= ((status & ~st_clr | st_set) & mask) != '0;
        end
    end
endmodule

/* File: testbench/tb_touch_switch_notify_lamp_bits.sv */
`timescale 1ns/1ps
`include "tsn_defs.svh"
module tb_touch_switch_notify_lamp_bits;
    logic                  sys_clk, reset_n, reg_wr, reg_rd, irq, screen_show, screen_leave;
    logic [7:0]            reg_addr, sw_pressed, lamp_bit, sw_lit;
    logic [31:0]           reg_wdata, reg_rdata, v;
    logic                  mem_req, mem_wr, mem_ack;
    tsn_pkg::tsn_area_type mem_area;
    logic [15:0]           mem_addr, mem_wdata, mem_mask, mem_rdata;
    int                    fails, total_checks, ones;
    tsn_top #(.NUM_SW(8), .BLINK_CYCLES(4)) dut (.*);
    tsn_mem_model pm (.*);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Pending only rises a cycle after the trigger, so give it time first
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 50; i++) begin
            rd(`TSN_OFF_PEND);
            if (v == 0) break;
        end
        // Pending clears at issue; the model may still hold two wait states
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic press(input int i, input logic lvl);
        @(posedge sys_clk);
        sw_pressed[i] <= lvl;
        settle();
    endtask
    task automatic pulse(input bit leave);
        @(posedge sys_clk);
        if (leave) screen_leave <= 1'b1;
        else screen_show <= 1'b1;
        @(posedge sys_clk);
        screen_show  <= 1'b0;
        screen_leave <= 1'b0;
        settle();
    endtask
    function automatic logic [15:0] m(input logic [2:0] ar, input logic [15:0] wd);
        return pm.mem[{ar, wd}];
    endfunction
    function automatic logic [31:0] cfg(input logic [2:0] ar, input logic fl,
                                        input logic [1:0] op, input logic [3:0] ix,
                                        input logic [15:0] wd);
        return {6'h00, ar, fl, op, ix, wd};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(25 * 40000);
        fails++;
        conclude();
    end
    initial begin
        {reset_n, reg_wr, reg_rd, screen_show, screen_leave} = 5'h00;
        {reg_addr, sw_pressed, lamp_bit, reg_wdata} = 56'h0;
        fails = 0;
        total_checks = 0;
        void'($urandom(32'hbe056faf));
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 'h48; a += 4) begin
            rd(a[7:0]);
            chk(v, 32'h0);
        end
        pm.mem[{3'h4, 16'h0020}] = 16'h1234;
        pm.mem[{3'h0, 16'h0006}] = 16'hFFFF;
        pm.mem[{3'h1, 16'h0005}] = 16'h00F0;
        wr(`TSN_OFF_CTRL, 32'h3);
        wr(`TSN_OFF_MASK, 32'h1);
        wr(8'h40, cfg(3'h4, 1'b0, 2'h0, 4'h3, 16'h0010));
        wr(8'h44, cfg(3'h4, 1'b1, 2'h1, 4'hF, 16'h0020));
        wr(8'h48, cfg(3'h1, 1'b0, 2'h2, 4'h0, 16'h0005));
        wr(8'h4C, cfg(3'h0, 1'b0, 2'h3, 4'h2, 16'h0006));
        wr(8'h50, cfg(3'h3, 1'b0, 2'h0, 4'h1, 16'h00C7));
        pulse(0);
        pm.mem[{3'h4, 16'h0020}] = 16'h0001;
        press(1, 1);
        chk(m(4, 16'h0020), 16'h9234);
        chk({31'h0, irq}, 32'h1);
        wr(`TSN_OFF_STATUS, 32'h1);
        @(posedge sys_clk);
        #1 chk({31'h0, irq}, 32'h0);
        press(1, 0);
        press(1, 1);
        chk(m(4, 16'h0020), 16'h1234);
        press(1, 0);
        press(0, 1);
        chk(m(4, 16'h0010), 16'h0008);
        rd(`TSN_OFF_NOTIFY);
        chk(v[0], 1'b1);
        press(0, 0);
        chk(m(4, 16'h0010), 16'h0000);
        for (int k = 0; k < 2; k++) begin
            press(2, 1);
            press(2, 0);
            press(3, 1);
            press(3, 0);
        end
        chk(m(1, 16'h0005), 16'h00F1);
        chk(m(0, 16'h0006), 16'hFFFB);
        press(4, 1);
        chk(m(0, 16'h04AF), 16'h0002);
        press(4, 0);
        chk(m(0, 16'h04AF), 16'h0000);
        press(0, 1);
        pulse(1);
        chk(m(4, 16'h0010), 16'h0000);
        press(0, 0);
        wr(`TSN_OFF_CTRL, 32'h1);
        pulse(0);
        press(1, 1);
        chk(m(4, 16'h0020), 16'h8000);
        press(1, 0);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            lamp_bit <= 8'($urandom) | 8'h02;
            repeat (3) @(posedge sys_clk);
            #1 chk(sw_lit & 8'hFD, lamp_bit & 8'hFD);
            ones = 0;
            repeat (8) begin
                @(posedge sys_clk);
                #1 ones += sw_lit[1];
            end
            chk(ones > 0 && ones < 8, 1'b1);
        end
        conclude();
    end
endmodule

/* File: testbench/tsn_mem_model.sv */
`timescale 1ns/1ps
module tsn_mem_model (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // Memory port
    input  wire logic                  mem_req,
    input  wire logic                  mem_wr,
    input  wire tsn_pkg::tsn_area_type mem_area,
    input  wire logic [15:0]           mem_addr,
    input  wire logic [15:0]           mem_wdata,
    input  wire logic [15:0]           mem_mask,
    output logic                       mem_ack,
    output logic [15:0]                mem_rdata
);
    logic [15:0] mem [logic [18:0]];
    logic [15:0] cur;
    int          wait_n;
    wire  [18:0] key = {mem_area, mem_addr};
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_n = 0;
        end else if (mem_ack) begin
            // Released data never repeats the last word
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && wait_n > 0) begin
            wait_n = wait_n - 1;
        end else if (mem_req) begin
            cur = mem.exists(key) ? mem[key] : 16'h0000;
            if (mem_wr)
                mem[key] = (cur & ~mem_mask) | (mem_wdata & mem_mask);
            mem_rdata <= cur;
            mem_ack   <= 1'b1;
            wait_n = $urandom % 3;
        end
    end
endmodule

/* File: testbench/tsn_top_checker.sv */
`timescale 1ns/1ps
module tsn_top_checker #(
    parameter int NUM_SW = 8
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              reset_n,
    // Register and panel
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [NUM_SW-1:0] lamp_bit,
    input wire logic [NUM_SW-1:0] sw_lit,
    // Memory port
    input wire logic              mem_req,
    input wire logic              mem_wr,
    input wire tsn_pkg::tsn_area_type mem_area,
    input wire logic [15:0]       mem_addr,
    input wire logic [15:0]       mem_wdata,
    input wire logic [15:0]       mem_mask,
    input wire logic              mem_ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read slot");
    a_req_holds_steady: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_wdata) && $stable(mem_mask) && $stable(mem_wr))
        else $error("memory request changed before ack");
    a_req_drops_ack: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request kept after ack");
    a_req_gap_two: assert property ($fell(mem_req) |-> !mem_req ##1 !mem_req)
        else $error("memory requests too close");
    a_write_mask_form: assert property (mem_req && mem_wr
        |-> mem_mask == 16'hFFFF || $onehot(mem_mask))
        else $error("write mask neither word nor single bit");
    a_read_mask_none: assert property (mem_req && !mem_wr |-> mem_mask == 16'h0000)
        else $error("snapshot read carries a mask");
    a_relay_low_mapped: assert property (mem_req && mem_area == tsn_pkg::TSN_AREA_LINK_RELAY
        |-> mem_addr > 16'h00C7)
        else $error("low relay word not translated");
    a_lamp_off_unlit: assert property ((sw_lit & ~$past(lamp_bit)) == '0)
        else $error("switch lit with lamp bit clear");
endmodule
bind tsn_top tsn_top_checker #(.NUM_SW(NUM_SW)) chk (.*);
